// [design/opd_pkg.sv]
// Constants, types and decode functions for the opcode decoder
// Operation
// - 000000dw plus addressing byte decodes as register/memory addition.
// - 100000sw with reg 000 decodes as immediate addition to register/memory.
// - 000100dw is add-with-carry reg/mem; 0001010w adds immediate with carry to accumulator.
// - 100000sw with reg 010 is immediate add-with-carry into register/memory.
// - Reg 101 immediate subtract; 001010dw reg/mem subtract; 0010110w accumulator subtract.
// - 000110dw is borrow subtract reg/mem; 0001110w borrow subtract from accumulator.
// - 100000sw with reg 011 is immediate borrow subtract on register/memory.
// - Reg 111 is immediate compare; second immediate byte only when s:w is 01.
// - Single byte 00110111 is unpacked decimal adjust after addition.
// - Single byte 00100111 is packed decimal adjust after addition.
// - Single byte 11010111 is the table lookup of the low accumulator byte.
// - 11000101 with addressing byte loads far pointer into register and data segment.
// - 11000100 with addressing byte loads far pointer into register and extra segment.
// - 9F, 9E, 9C, 9D are the four single-byte flag transfers.
// - 8C copies segment to reg/mem, 8E the reverse; reg field top bit zero.
package opd_pkg;

  localparam logic [7:0] OPC_ADD_RM = 8'h00;
  localparam logic [7:0] OPC_ADC_RM = 8'h10;
  localparam logic [7:0] OPC_SBB_RM = 8'h18;
  localparam logic [7:0] OPC_SUB_RM = 8'h28;
  localparam logic [7:0] OPC_CMP_RM = 8'h38;
  localparam logic [7:0] MASK_RM = 8'hfc;
  localparam logic [7:0] OPC_ADD_ACC = 8'h04;
  localparam logic [7:0] OPC_ADC_ACC = 8'h14;
  localparam logic [7:0] OPC_SBB_ACC = 8'h1c;
  localparam logic [7:0] OPC_SUB_ACC = 8'h2c;
  localparam logic [7:0] OPC_CMP_ACC = 8'h3c;
  localparam logic [7:0] MASK_ACC = 8'hfe;
  localparam logic [7:0] OPC_IMM_GRP = 8'h80;
  localparam logic [7:0] OPC_UNPACKED_ADJ = 8'h37;
  localparam logic [7:0] OPC_PACKED_ADJ = 8'h27;
  localparam logic [7:0] OPC_TABLE_LOOKUP = 8'hd7;
  localparam logic [7:0] OPC_FAR_DATA = 8'hc5;
  localparam logic [7:0] OPC_FAR_EXTRA = 8'hc4;
  localparam logic [7:0] OPC_LOAD_HIGH_ACC = 8'h9f;
  localparam logic [7:0] OPC_STORE_HIGH_ACC = 8'h9e;
  localparam logic [7:0] OPC_PUSH_FLAGS = 8'h9c;
  localparam logic [7:0] OPC_POP_FLAGS = 8'h9d;
  localparam logic [7:0] OPC_COPY_SEG_TO_RM = 8'h8c;
  localparam logic [7:0] OPC_COPY_RM_TO_SEG = 8'h8e;

  localparam int BIT_W = 0;
  localparam int BIT_D = 1;
  localparam int BIT_S = 1;

  localparam logic [2:0] GRP_ADD = 3'b000;
  localparam logic [2:0] GRP_ADC = 3'b010;
  localparam logic [2:0] GRP_SBB = 3'b011;
  localparam logic [2:0] GRP_SUB = 3'b101;
  localparam logic [2:0] GRP_CMP = 3'b111;

  localparam logic [1:0] MOD_NO_DISP = 2'b00;
  localparam logic [1:0] MOD_DISP8 = 2'b01;
  localparam logic [1:0] MOD_DISP16 = 2'b10;
  localparam logic [2:0] RM_DIRECT = 3'b110;

  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_ADD = 5'h01,
    OP_ADC = 5'h02,
    OP_SUB = 5'h03,
    OP_DIFFERENCE_WITH_BORROW = 5'h04,
    OP_COMPARE = 5'h05,
    OP_UNPACKED_BCD_SUM_ADJUST = 5'h06,
    OP_PACKED_BCD_SUM_ADJUST = 5'h07,
    OP_TABLE_LOOKUP_BYTE = 5'h08,
    OP_LOAD_FAR_POINTER_DATA_SEG = 5'h09,
    OP_LOAD_FAR_POINTER_EXTRA_SEG = 5'h0a,
    OP_LOAD_HIGH_ACC_FROM_FLAGS = 5'h0b,
    OP_STORE_HIGH_ACC_TO_FLAGS = 5'h0c,
    OP_PUSH_FLAG_WORD = 5'h0d,
    OP_POP_FLAG_WORD = 5'h0e,
    OP_COPY_SEG_TO_RM = 5'h0f,
    OP_COPY_RM_TO_SEG = 5'h10
  } opd_op_type;

  typedef enum logic [2:0] {
    FORM_NONE = 3'b000,
    FORM_REG_RM = 3'b001,
    FORM_IMM_RM = 3'b010,
    FORM_IMM_ACC = 3'b011,
    FORM_MEM_PTR = 3'b100,
    FORM_SEG_RM = 3'b101
  } opd_form_type;

  typedef enum logic [1:0] {
    ST_OPCODE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DISP = 2'b10,
    ST_IMM = 2'b11
  } opd_state_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } opd_byte_type;

  typedef struct packed {
    opd_op_type op;
    opd_form_type form;
    logic word;
    logic dest_is_reg;
    logic sign_ext;
    logic [1:0] mode;
    logic [2:0] reg_field;
    logic [2:0] rm_field;
    logic [1:0] disp_count;
    logic [15:0] disp;
    logic [1:0] imm_count;
    logic [15:0] imm;
  } opd_dec_type;

  localparam opd_dec_type DEC_RESET = '{op: OP_NONE, form: FORM_NONE, default: '0};

  // First-byte decode; op of the immediate group waits for the reg field
  function automatic opd_dec_type opd_first(input logic [7:0] b);
    opd_dec_type d;
    d = DEC_RESET;
    d.word = b[BIT_W];
    if ((b & MASK_RM) == OPC_ADD_RM || (b & MASK_RM) == OPC_ADC_RM ||
        (b & MASK_RM) == OPC_SBB_RM || (b & MASK_RM) == OPC_SUB_RM ||
        (b & MASK_RM) == OPC_CMP_RM) begin
      d.form = FORM_REG_RM;
      d.dest_is_reg = b[BIT_D];
      unique case (b & MASK_RM)
        OPC_ADD_RM: d.op = OP_ADD;
        OPC_ADC_RM: d.op = OP_ADC;
        OPC_SBB_RM: d.op = OP_DIFFERENCE_WITH_BORROW;
        OPC_SUB_RM: d.op = OP_SUB;
        default: d.op = OP_COMPARE;
      endcase
    end else if ((b & MASK_ACC) == OPC_ADD_ACC || (b & MASK_ACC) == OPC_ADC_ACC ||
                 (b & MASK_ACC) == OPC_SBB_ACC || (b & MASK_ACC) == OPC_SUB_ACC ||
                 (b & MASK_ACC) == OPC_CMP_ACC) begin
      d.form = FORM_IMM_ACC;
      d.dest_is_reg = 1'b1;
      d.imm_count = b[BIT_W] ? 2'd2 : 2'd1;
      unique case (b & MASK_ACC)
        OPC_ADD_ACC: d.op = OP_ADD;
        OPC_ADC_ACC: d.op = OP_ADC;
        OPC_SBB_ACC: d.op = OP_DIFFERENCE_WITH_BORROW;
        OPC_SUB_ACC: d.op = OP_SUB;
        default: d.op = OP_COMPARE;
      endcase
    end else if ((b & MASK_RM) == OPC_IMM_GRP) begin
      d.form = FORM_IMM_RM;
      d.imm_count = (b[BIT_S] == 1'b0 && b[BIT_W] == 1'b1) ? 2'd2 : 2'd1;
      d.sign_ext = b[BIT_S] & b[BIT_W];
    end else begin
      unique case (b)
        OPC_UNPACKED_ADJ: d.op = OP_UNPACKED_BCD_SUM_ADJUST;
        OPC_PACKED_ADJ: d.op = OP_PACKED_BCD_SUM_ADJUST;
        OPC_TABLE_LOOKUP: d.op = OP_TABLE_LOOKUP_BYTE;
        OPC_FAR_DATA: d.op = OP_LOAD_FAR_POINTER_DATA_SEG;
        OPC_FAR_EXTRA: d.op = OP_LOAD_FAR_POINTER_EXTRA_SEG;
        OPC_LOAD_HIGH_ACC: d.op = OP_LOAD_HIGH_ACC_FROM_FLAGS;
        OPC_STORE_HIGH_ACC: d.op = OP_STORE_HIGH_ACC_TO_FLAGS;
        OPC_PUSH_FLAGS: d.op = OP_PUSH_FLAG_WORD;
        OPC_POP_FLAGS: d.op = OP_POP_FLAG_WORD;
        OPC_COPY_SEG_TO_RM: d.op = OP_COPY_SEG_TO_RM;
        OPC_COPY_RM_TO_SEG: d.op = OP_COPY_RM_TO_SEG;
        default: d.op = OP_NONE;
      endcase
      if (b == OPC_FAR_DATA || b == OPC_FAR_EXTRA) begin
        d.form = FORM_MEM_PTR;
        d.word = 1'b1;
        d.dest_is_reg = 1'b1;
      end else if (b == OPC_COPY_SEG_TO_RM || b == OPC_COPY_RM_TO_SEG) begin
        d.form = FORM_SEG_RM;
        d.word = 1'b1;
        d.dest_is_reg = b[BIT_D];
      end
      if (b == OPC_TABLE_LOOKUP) begin
        d.word = 1'b0;
      end
    end
    return d;
  endfunction

  // Immediate group operation from the reg field, OP_NONE when not handled here
  function automatic opd_op_type opd_group(input logic [2:0] r);
    unique case (r)
      GRP_ADD: return OP_ADD;
      GRP_ADC: return OP_ADC;
      GRP_SBB: return OP_DIFFERENCE_WITH_BORROW;
      GRP_SUB: return OP_SUB;
      GRP_CMP: return OP_COMPARE;
      default: return OP_NONE;
    endcase
  endfunction

  // Displacement bytes that follow the addressing byte
  function automatic logic [1:0] opd_disp(input logic [1:0] m, input logic [2:0] rm);
    if (m == MOD_DISP8) begin
      return 2'd1;
    end else if (m == MOD_DISP16 || (m == MOD_NO_DISP && rm == RM_DIRECT)) begin
      return 2'd2;
    end
    return 2'd0;
  endfunction

endpackage

// [design/opd_decoder.sv]
// Opcode decoder for the transfer and arithmetic instruction groups
`timescale 1ns/1ns
module opd_decoder (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire opd_pkg::opd_byte_type byte_i,
  output logic dec_valid_o,
  output logic unsupported_o,
  output opd_pkg::opd_dec_type dec_o
);
  import opd_pkg::*;

  typedef struct packed {
    opd_state_type state;
    logic first;
    logic [1:0] left;
    opd_dec_type dec;
    logic dec_valid;
    logic unsupported;
  } opd_regs_type;

  localparam opd_regs_type REGS_RESET = '{state: ST_OPCODE, dec: DEC_RESET, default: '0};

  opd_regs_type r;
  opd_regs_type next_r;

  always_comb begin
    logic finish;
    logic bad;
    opd_dec_type d;
    finish = 1'b0;
    bad = 1'b0;
    d = DEC_RESET;
    next_r = r;
    next_r.dec_valid = 1'b0;
    next_r.unsupported = 1'b0;
    if (byte_i.valid) begin
      unique case (r.state)
        ST_OPCODE: begin
          d = opd_first(byte_i.data);
          next_r.dec = d;
          next_r.first = 1'b1;
          if (d.form == FORM_NONE && d.op == OP_NONE) begin
            // Length unknown, so resync on the next byte
            next_r.unsupported = 1'b1;
          end else if (d.form != FORM_NONE && d.form != FORM_IMM_ACC) begin
            next_r.state = ST_ADDR;
          end else if (d.imm_count != 2'd0) begin
            next_r.state = ST_IMM;
            next_r.left = d.imm_count;
          end else begin
            finish = 1'b1;
          end
        end
        ST_ADDR: begin
          next_r.dec.mode = byte_i.data[7:6];
          next_r.dec.reg_field = byte_i.data[5:3];
          next_r.dec.rm_field = byte_i.data[2:0];
          next_r.dec.disp_count = opd_disp(byte_i.data[7:6], byte_i.data[2:0]);
          if (r.dec.form == FORM_IMM_RM) begin
            next_r.dec.op = opd_group(byte_i.data[5:3]);
            next_r.dec.dest_is_reg = 1'b0;
          end
          if (r.dec.form == FORM_SEG_RM && byte_i.data[5] != 1'b0) begin
            bad = 1'b1;
          end
          if (next_r.dec.disp_count != 2'd0) begin
            next_r.state = ST_DISP;
            next_r.left = next_r.dec.disp_count;
            next_r.first = 1'b1;
          end else if (r.dec.imm_count != 2'd0) begin
            next_r.state = ST_IMM;
            next_r.left = r.dec.imm_count;
            next_r.first = 1'b1;
          end else begin
            finish = 1'b1;
          end
          // Group codes outside this block still consume their bytes
          if (r.dec.form == FORM_IMM_RM && opd_group(byte_i.data[5:3]) == OP_NONE) begin
            next_r.dec.op = OP_NONE;
          end
        end
        ST_DISP: begin
          if (r.first) begin
            next_r.dec.disp = {{8{byte_i.data[7]}}, byte_i.data};
          end else begin
            next_r.dec.disp[15:8] = byte_i.data;
          end
          next_r.first = 1'b0;
          next_r.left = r.left - 2'd1;
          if (r.left == 2'd1) begin
            if (r.dec.imm_count != 2'd0) begin
              next_r.state = ST_IMM;
              next_r.left = r.dec.imm_count;
              next_r.first = 1'b1;
            end else begin
              finish = 1'b1;
            end
          end
        end
        ST_IMM: begin
          if (r.first) begin
            // Single-byte immediates zero-extend unless both the sign and width bits are set
            next_r.dec.imm = r.dec.sign_ext ? {{8{byte_i.data[7]}}, byte_i.data} :
                                              {8'h00, byte_i.data};
          end else begin
            next_r.dec.imm[15:8] = byte_i.data;
          end
          next_r.first = 1'b0;
          next_r.left = r.left - 2'd1;
          if (r.left == 2'd1) begin
            finish = 1'b1;
          end
        end
      endcase
    end
    if (finish || (bad && r.state == ST_ADDR)) begin
      next_r.state = ST_OPCODE;
      next_r.left = 2'd0;
    end
    if (finish) begin
      if (bad || next_r.dec.op == OP_NONE) begin
        next_r.unsupported = 1'b1;
      end else begin
        next_r.dec_valid = 1'b1;
      end
    end else if (bad) begin
      // Bad segment code with displacement: flag now, back to opcode without consuming its displacement bytes
      next_r.unsupported = 1'b1;
      next_r.state = ST_OPCODE;
    end
  end

  // Clock enable low freezes every flop, outputs included
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= REGS_RESET;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign dec_valid_o = r.dec_valid;
  assign unsupported_o = r.unsupported;
  assign dec_o = r.dec;

endmodule

// [test/opd_monitor.sv]
// Port assertions for the opcode decoder
`timescale 1ns/1ns
module opd_monitor
  import opd_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire opd_pkg::opd_byte_type byte_i,
  input wire logic dec_valid_o,
  input wire logic unsupported_o,
  input wire opd_pkg::opd_dec_type dec_o
);
  logic at_op;
  logic first;
  logic take;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  assign take = ce_i && byte_i.valid;
  // Next taken byte is an opcode
  assign first = at_op || dec_valid_o || unsupported_o;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      at_op <= 1'b1;
    end else if (take) begin
      at_op <= 1'b0;
    end else if (dec_valid_o || unsupported_o) begin
      at_op <= 1'b1;
    end
  end
  pulse_once_a: assert property (dec_valid_o && take == 1'b0 && ce_i |=> !dec_valid_o)
    else $error("decode pulse stood too long");
  answer_cause_a: assert property (dec_valid_o && $past(ce_i) |-> $past(byte_i.valid))
    else $error("decode pulse without a taken byte");
  unpacked_adj_a: assert property (take && first && byte_i.data == 8'h37 |=>
    dec_valid_o && dec_o.op == OP_UNPACKED_BCD_SUM_ADJUST) else $error("adjust not decoded");
  lookup_byte_a: assert property (take && first && byte_i.data == 8'hd7 |=>
    dec_valid_o && dec_o.op == OP_TABLE_LOOKUP_BYTE && !dec_o.word) else $error("lookup wrong");
  flag_xfer_a: assert property (take && first && byte_i.data[7:2] == 6'b100111 |=>
    dec_valid_o && dec_o.form == FORM_NONE) else $error("flag transfer wrong");
  imm_width_a: assert property (dec_valid_o && dec_o.form == FORM_IMM_RM |->
    dec_o.imm_count == ((dec_o.word && !dec_o.sign_ext) ? 2'd2 : 2'd1))
    else $error("group immediate count wrong");
  sign_fill_a: assert property (dec_valid_o && dec_o.sign_ext |->
    dec_o.imm[15:8] == {8{dec_o.imm[7]}}) else $error("immediate not sign extended");
  acc_width_a: assert property (dec_valid_o && dec_o.form == FORM_IMM_ACC |->
    dec_o.imm_count == (dec_o.word ? 2'd2 : 2'd1)) else $error("accumulator count wrong");
  seg_dir_a: assert property (dec_valid_o && dec_o.form == FORM_SEG_RM |->
    !dec_o.reg_field[2] && dec_o.dest_is_reg == (dec_o.op == OP_COPY_RM_TO_SEG))
    else $error("segment copy wrong");
  cover property (dec_valid_o && dec_o.form == FORM_IMM_RM);
  cover property (dec_valid_o && dec_o.form == FORM_IMM_ACC);
  cover property (unsupported_o);
endmodule

// [test/opd_feeder.sv]
// Prefetch stream model offering bytes to the decoder
`timescale 1ns/1ns
module opd_feeder
  import opd_pkg::*;
(
  input wire logic clock_i,
  output opd_pkg::opd_byte_type byte_o
);
  logic [7:0] last;
  initial begin
    byte_o = '0;
    last = 8'h00;
  end
  task automatic put(input logic [7:0] b);
    @(negedge clock_i);
    byte_o <= '{valid: 1'b1, data: b};
    last = b;
  endtask
  // Inverse data when idle, so a stale byte never looks fresh
  task automatic idle();
    @(negedge clock_i);
    byte_o <= '{valid: 1'b0, data: ~last};
  endtask
endmodule

// [test/opd_decoder_tb.sv]
// Self-checking bench for the opcode decoder
`timescale 1ns/1ns
module opd_decoder_tb;
  import opd_pkg::*;
  typedef logic [7:0] opd_bq_type [$];
  logic clock_i;
  logic resetn_i;
  logic ce_i;
  opd_byte_type byte_i;
  logic dec_valid_o;
  logic unsupported_o;
  opd_dec_type dec_o;
  int bad_count;
  int check_count;
  opd_feeder i_opd_feeder (.clock_i(clock_i), .byte_o(byte_i));
  opd_decoder i_opd_decoder (.clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .byte_i(byte_i), .dec_valid_o(dec_valid_o), .unsupported_o(unsupported_o), .dec_o(dec_o));
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Bytes back to back, then one idle cycle where the answer stands
  task automatic instr(input opd_bq_type q, input opd_op_type op, input opd_form_type f,
    input logic w, input logic [1:0] n, input logic [15:0] imm);
    foreach (q[i]) begin
      i_opd_feeder.put(q[i]);
    end
    i_opd_feeder.idle();
    chk("dec_valid", 1, dec_valid_o);
    chk("op", op, dec_o.op);
    chk("form", f, dec_o.form);
    chk("word", w, dec_o.word);
    chk("imm_count", n, dec_o.imm_count);
    chk("imm", imm, dec_o.imm);
  endtask
  task automatic t_reg_rm();
    opd_op_type ops[4] = '{OP_ADD, OP_ADC, OP_SUB, OP_DIFFERENCE_WITH_BORROW};
    logic [7:0] opc[4] = '{8'h03, 8'h13, 8'h2b, 8'h1b};
    for (int i = 0; i < 4; i++) begin
      instr({opc[i], 8'hc1}, ops[i], FORM_REG_RM, 1'b1, 2'd0, 16'h0000);
      chk("dest", 1, dec_o.dest_is_reg);
    end
    instr({8'h00, 8'h45, 8'h10}, OP_ADD, FORM_REG_RM, 1'b0, 2'd0, 16'h0000);
    chk("dest", 0, dec_o.dest_is_reg);
    chk("disp", 16'h0010, dec_o.disp);
    chk("disp_count", 1, dec_o.disp_count);
    chk("rm", 3'b101, dec_o.rm_field);
  endtask
  task automatic t_acc();
    instr({8'h15, 8'h34, 8'h12}, OP_ADC, FORM_IMM_ACC, 1'b1, 2'd2, 16'h1234);
    instr({8'h2c, 8'h7f}, OP_SUB, FORM_IMM_ACC, 1'b0, 2'd1, 16'h007f);
    instr({8'h1d, 8'h01, 8'h80}, OP_DIFFERENCE_WITH_BORROW, FORM_IMM_ACC, 1'b1, 2'd2,
      16'h8001);
  endtask
  task automatic t_group();
    logic [2:0] r[5] = '{3'b000, 3'b010, 3'b011, 3'b101, 3'b111};
    opd_op_type ops[5] = '{OP_ADD, OP_ADC, OP_DIFFERENCE_WITH_BORROW, OP_SUB, OP_COMPARE};
    logic [7:0] m;
    for (int i = 0; i < 5; i++) begin
      m = {2'b11, r[i], 3'b000};
      instr({8'h81, m, 8'h34, 8'h12}, ops[i], FORM_IMM_RM, 1'b1, 2'd2, 16'h1234);
    end
    instr({8'h83, 8'hf8, 8'h80}, OP_COMPARE, FORM_IMM_RM, 1'b1, 2'd1, 16'hff80);
    instr({8'h82, 8'hc0, 8'h80}, OP_ADD, FORM_IMM_RM, 1'b0, 2'd1, 16'h0080);
    instr({8'h80, 8'h06, 8'h00, 8'h20, 8'h55}, OP_ADD, FORM_IMM_RM, 1'b0, 2'd1, 16'h0055);
    chk("disp", 16'h2000, dec_o.disp);
    chk("mode", 0, dec_o.mode);
  endtask
  task automatic t_single();
    logic [7:0] b[7] = '{8'h37, 8'h27, 8'hd7, 8'h9f, 8'h9e, 8'h9c, 8'h9d};
    opd_op_type ops[7] = '{OP_UNPACKED_BCD_SUM_ADJUST, OP_PACKED_BCD_SUM_ADJUST,
      OP_TABLE_LOOKUP_BYTE, OP_LOAD_HIGH_ACC_FROM_FLAGS, OP_STORE_HIGH_ACC_TO_FLAGS,
      OP_PUSH_FLAG_WORD, OP_POP_FLAG_WORD};
    for (int i = 0; i < 7; i++) begin
      instr({b[i]}, ops[i], FORM_NONE, b[i][0] && b[i] != 8'hd7, 2'd0,
        16'h0000);
    end
    i_opd_feeder.put(8'h27);
    instr({8'h37}, OP_UNPACKED_BCD_SUM_ADJUST, FORM_NONE, 1'b1, 2'd0, 16'h0000);
  endtask
  task automatic t_ptr_seg();
    instr({8'hc5, 8'h47, 8'h10}, OP_LOAD_FAR_POINTER_DATA_SEG, FORM_MEM_PTR, 1'b1, 2'd0,
      0);
    instr({8'hc4, 8'h07}, OP_LOAD_FAR_POINTER_EXTRA_SEG, FORM_MEM_PTR, 1'b1, 2'd0, 0);
    instr({8'h8c, 8'hd8}, OP_COPY_SEG_TO_RM, FORM_SEG_RM, 1'b1, 2'd0, 16'h0000);
    chk("dest", 0, dec_o.dest_is_reg);
    chk("reg", 3'b011, dec_o.reg_field);
    instr({8'h8e, 8'hd8}, OP_COPY_RM_TO_SEG, FORM_SEG_RM, 1'b1, 2'd0, 16'h0000);
    chk("dest", 1, dec_o.dest_is_reg);
    i_opd_feeder.put(8'h8e);
    i_opd_feeder.put(8'he0);
    i_opd_feeder.idle();
    chk("unsupported", 1, unsupported_o);
    chk("dec_valid", 0, dec_valid_o);
    // Group code outside this block must still swallow its immediate byte
    i_opd_feeder.put(8'h80);
    i_opd_feeder.put(8'hc8);
    i_opd_feeder.put(8'h55);
    i_opd_feeder.idle();
    chk("unsupported", 1, unsupported_o);
    chk("dec_valid", 0, dec_valid_o);
  endtask
  // Clock enable low must hold the byte back, not drop it
  task automatic t_stall();
    i_opd_feeder.put(8'h05);
    i_opd_feeder.put(8'h34);
    ce_i <= 1'b0;
    i_opd_feeder.put(8'h34);
    i_opd_feeder.put(8'h34);
    // Two stalled edges passed: an ignored enable would have finished by now
    chk("dec_valid", 0, dec_valid_o);
    chk("imm", 16'h0000, dec_o.imm);
    ce_i <= 1'b1;
    instr({8'h12}, OP_ADD, FORM_IMM_ACC, 1'b1, 2'd2, 16'h1234);
  endtask
  // Reset in mid-instruction must drop the half-built decode
  task automatic t_reset();
    i_opd_feeder.put(8'h81);
    i_opd_feeder.put(8'hc0);
    i_opd_feeder.idle();
    resetn_i = 1'b0;
    i_opd_feeder.idle();
    resetn_i = 1'b1;
    chk("dec_valid", 0, dec_valid_o);
    chk("op", OP_NONE, dec_o.op);
    instr({8'h37}, OP_UNPACKED_BCD_SUM_ADJUST, FORM_NONE, 1'b1, 2'd0, 16'h0000);
  endtask
  initial begin
    bad_count = 0;
    check_count = 0;
    resetn_i = 1'b0;
    ce_i = 1'b1;
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    resetn_i = 1'b1;
    chk("dec_valid", 0, dec_valid_o);
    chk("op", OP_NONE, dec_o.op);
    t_reg_rm();
    t_acc();
    t_group();
    t_single();
    t_ptr_seg();
    t_stall();
    t_reset();
    end_of_test();
  end
  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end
endmodule
bind opd_decoder opd_monitor i_opd_monitor (.clock_i(clock_i), .resetn_i(resetn_i),
  .ce_i(ce_i), .byte_i(byte_i), .dec_valid_o(dec_valid_o), .unsupported_o(unsupported_o),
  .dec_o(dec_o));
